// ---- verilog/sep_pkg.sv ----
// Constants and state type for the serial EEPROM read path.
// Assumes one core clock domain; bus pins arrive asynchronously.
// Behaviour
// - Reads ignore the write-mode selection pin
// - Unwritten storage reads as all ones
// - Address counter advances after each sent byte
// - Current read: ack select, send, advance
// - Repeated START, read select, send loaded byte
// - Sequential read starts either way
// - Master ack keeps next byte coming
// - Counter wraps past top, data continues
// - No ack in ninth slot: go standby
// - Select: type, device, block, direction
// - Respond only when device bits match pins
// - Eight-bit address byte loaded and acknowledged
// - Busy programming: ignore bus, never acknowledge
package sep_pkg;
    localparam int          MEM_DEPTH   = 512;
    localparam int          ADDR_W      = 9;
    localparam int          BUF_DEPTH   = 2;
    localparam logic [7:0]  BYTE_ERASED = 8'hFF;
    localparam logic [8:0]  ADDR_RST    = 9'h000;
    localparam logic [3:0]  RX_BITS     = 4'h8;
    localparam logic [2:0]  BIT_MSB     = 3'h7;
    localparam logic [3:0]  PIN_RST     = 4'hF;
    localparam int          PIN_SCL     = 0;
    localparam int          PIN_SDA     = 1;
    localparam int          PIN_CS_LO   = 2;
    localparam int          PIN_CS_HI   = 3;
    localparam int          SEL_TYPE_HI = 7;
    localparam int          SEL_TYPE_LO = 4;
    localparam int          SEL_CS_HI   = 3;
    localparam int          SEL_CS_LO   = 2;
    localparam int          SEL_BLOCK   = 1;
    localparam int          SEL_DIR     = 0;
    localparam logic [1:0]  BUF_FULL    = 2'h2;
    localparam logic [1:0]  BUF_EMPTY   = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEVSEL,
        ST_DEV_ACK,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_WAIT
    } sep_state_e;
endpackage

// ---- verilog/sep_read_path.sv ----
// Two-wire EEPROM target, read side, with flip-flop storage.
// Assumes scl/sda/chip selects are async pins; the write side drives mem_wr_*
// and prog_busy on core_clk.
module sep_read_path #(
    parameter logic [3:0] DEV_TYPE_CODE = 4'h5 // Arbitrary value
) (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       chip_select_low_bit,
    input  wire logic       chip_select_high_bit,
    input  wire logic       write_mode_sel,
    input  wire logic       prog_busy,
    input  wire logic       mem_wr_en,
    input  wire logic [8:0] mem_wr_addr,
    input  wire logic [7:0] mem_wr_data
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Pin synchronisers; a level counts once stages two and three agree
    logic [3:0] pin_in;
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] lvl_q;
    logic [3:0] lvl_d;
    logic [3:0] prev_q;
    logic [3:0] agree;

    assign pin_in = {chip_select_high_bit, chip_select_low_bit, sda_in, scl_in};
    assign agree  = ~(s2_q ^ s3_q);
    assign lvl_d  = (agree & s2_q) | (~agree & lvl_q);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s1_q   <= sep_pkg::PIN_RST;
            s2_q   <= sep_pkg::PIN_RST;
            s3_q   <= sep_pkg::PIN_RST;
            lvl_q  <= sep_pkg::PIN_RST;
            prev_q <= sep_pkg::PIN_RST;
        end else begin
            s1_q   <= pin_in;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            lvl_q  <= lvl_d;
            prev_q <= lvl_q;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic start_ev;
    logic stop_ev;
    logic scl_hold;

    assign sda_lvl  = lvl_q[sep_pkg::PIN_SDA];
    assign scl_hold = lvl_q[sep_pkg::PIN_SCL] & prev_q[sep_pkg::PIN_SCL];
    assign scl_rise = lvl_q[sep_pkg::PIN_SCL] & ~prev_q[sep_pkg::PIN_SCL];
    assign scl_fall = ~lvl_q[sep_pkg::PIN_SCL] & prev_q[sep_pkg::PIN_SCL];
    assign start_ev = scl_hold & prev_q[sep_pkg::PIN_SDA] & ~sda_lvl;
    assign stop_ev  = scl_hold & ~prev_q[sep_pkg::PIN_SDA] & sda_lvl;

    // Storage; the write side only loads it, reads come through the buffer
    logic [7:0] mem_q [sep_pkg::MEM_DEPTH];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < sep_pkg::MEM_DEPTH; i++) begin
                mem_q[i] <= sep_pkg::BYTE_ERASED;
            end
        end else if (mem_wr_en) begin
            mem_q[mem_wr_addr] <= mem_wr_data;
        end
    end

    sep_pkg::sep_state_e state_q;
    sep_pkg::sep_state_e state_d;
    logic [3:0]          cnt_q;
    logic [3:0]          cnt_d;
    logic [7:0]          shift_q;
    logic [7:0]          shift_d;
    logic [8:0]          addr_q;
    logic [8:0]          addr_d;
    logic                rw_q;
    logic                rw_d;
    logic                acked_q;
    logic                acked_d;
    logic                oe_q;
    logic                oe_d;
    logic                flush;
    logic                pop;

    // Prefetch buffer between storage and the shifter
    logic [7:0] buf_q [sep_pkg::BUF_DEPTH];
    logic       wp_q;
    logic       rp_q;
    logic [1:0] buf_cnt_q;
    logic [8:0] fetch_q;
    logic       fetch_act;
    logic       in_ready;
    logic       out_valid;
    logic       push;
    logic       pop_v;
    logic [7:0] buf_out;

    // Fetch pointer is separate from the counter, so a prefetched byte
    // that is never sent does not move the visible address.
    assign fetch_act = (state_q == sep_pkg::ST_DEV_ACK && rw_q) ||
                       state_q == sep_pkg::ST_TX || state_q == sep_pkg::ST_TX_ACK;
    assign in_ready  = buf_cnt_q != sep_pkg::BUF_FULL;
    assign out_valid = buf_cnt_q != sep_pkg::BUF_EMPTY;
    assign push      = fetch_act & in_ready & ~flush;
    assign pop_v     = pop & out_valid;
    // Empty buffer only after a stalled fetch; erased value is the safe fill
    assign buf_out   = out_valid ? buf_q[rp_q] : sep_pkg::BYTE_ERASED;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wp_q      <= 1'b0;
            rp_q      <= 1'b0;
            buf_cnt_q <= sep_pkg::BUF_EMPTY;
            fetch_q   <= sep_pkg::ADDR_RST;
            for (int i = 0; i < sep_pkg::BUF_DEPTH; i++) begin
                buf_q[i] <= sep_pkg::BYTE_ERASED;
            end
        end else if (flush) begin
            wp_q      <= 1'b0;
            rp_q      <= 1'b0;
            buf_cnt_q <= sep_pkg::BUF_EMPTY;
            fetch_q   <= {shift_q[sep_pkg::SEL_BLOCK], addr_q[7:0]};
        end else begin
            if (push) begin
                buf_q[wp_q] <= mem_q[fetch_q];
                wp_q        <= ~wp_q;
                fetch_q     <= fetch_q + 9'h001;
            end
            if (pop_v) begin
                rp_q <= ~rp_q;
            end
            buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop_v};
        end
    end

    // Select decode; write_mode_sel is deliberately not looked at
    logic sel_match;
    logic [1:0] cs_lvl;
    assign cs_lvl    = {lvl_q[sep_pkg::PIN_CS_HI], lvl_q[sep_pkg::PIN_CS_LO]};
    assign sel_match = shift_q[sep_pkg::SEL_TYPE_HI:sep_pkg::SEL_TYPE_LO] == DEV_TYPE_CODE &&
                       shift_q[sep_pkg::SEL_CS_HI:sep_pkg::SEL_CS_LO] == cs_lvl &&
                       !prog_busy;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        shift_d = shift_q;
        addr_d  = addr_q;
        rw_d    = rw_q;
        acked_d = acked_q;
        oe_d    = oe_q;
        flush   = 1'b0;
        pop     = 1'b0;
        case (state_q)
            sep_pkg::ST_DEVSEL, sep_pkg::ST_ADDR: begin
                if (scl_rise && cnt_q != sep_pkg::RX_BITS) begin
                    shift_d = {shift_q[6:0], sda_lvl};
                    cnt_d   = cnt_q + 4'h1;
                end else if (scl_fall && cnt_q == sep_pkg::RX_BITS) begin
                    if (state_q == sep_pkg::ST_ADDR) begin
                        oe_d        = 1'b1;
                        addr_d[7:0] = shift_q;
                        state_d     = sep_pkg::ST_ADDR_ACK;
                    end else if (sel_match) begin
                        oe_d      = 1'b1;
                        rw_d      = shift_q[sep_pkg::SEL_DIR];
                        addr_d[8] = shift_q[sep_pkg::SEL_BLOCK];
                        flush     = shift_q[sep_pkg::SEL_DIR];
                        state_d   = sep_pkg::ST_DEV_ACK;
                    end else begin
                        state_d = sep_pkg::ST_WAIT;
                    end
                end
            end
            sep_pkg::ST_DEV_ACK: begin
                if (scl_fall) begin
                    cnt_d = 4'h0;
                    if (rw_q) begin
                        pop     = 1'b1;
                        shift_d = buf_out;
                        oe_d    = ~buf_out[sep_pkg::BIT_MSB];
                        state_d = sep_pkg::ST_TX;
                    end else begin
                        oe_d    = 1'b0;
                        state_d = sep_pkg::ST_ADDR;
                    end
                end
            end
            sep_pkg::ST_ADDR_ACK: begin
                if (scl_fall) begin
                    oe_d    = 1'b0;
                    state_d = sep_pkg::ST_WAIT;
                end
            end
            sep_pkg::ST_TX: begin
                if (scl_rise) begin
                    cnt_d = cnt_q + 4'h1;
                end else if (scl_fall) begin
                    if (cnt_q == sep_pkg::RX_BITS) begin
                        oe_d    = 1'b0;
                        addr_d  = addr_q + 9'h001;
                        acked_d = 1'b0;
                        state_d = sep_pkg::ST_TX_ACK;
                    end else begin
                        oe_d = ~shift_q[sep_pkg::BIT_MSB - cnt_q[2:0]];
                    end
                end
            end
            sep_pkg::ST_TX_ACK: begin
                if (scl_rise) begin
                    if (sda_lvl) begin
                        state_d = sep_pkg::ST_WAIT;
                    end else begin
                        acked_d = 1'b1;
                    end
                end else if (scl_fall && acked_q) begin
                    pop     = 1'b1;
                    cnt_d   = 4'h0;
                    shift_d = buf_out;
                    oe_d    = ~buf_out[sep_pkg::BIT_MSB];
                    state_d = sep_pkg::ST_TX;
                end
            end
            default: begin
            end
        endcase
        if (start_ev) begin
            cnt_d   = 4'h0;
            oe_d    = 1'b0;
            state_d = prog_busy ? sep_pkg::ST_WAIT : sep_pkg::ST_DEVSEL;
        end
        if (stop_ev) begin
            oe_d    = 1'b0;
            state_d = sep_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= sep_pkg::ST_IDLE;
            cnt_q   <= 4'h0;
            shift_q <= 8'h00;
            addr_q  <= sep_pkg::ADDR_RST;
            rw_q    <= 1'b0;
            acked_q <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            shift_q <= shift_d;
            addr_q  <= addr_d;
            rw_q    <= rw_d;
            acked_q <= acked_d;
            oe_q    <= oe_d;
        end
    end

    // Open drain: the pin is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe  = oe_q;

    a_sel_ack: assert property ((state_q == sep_pkg::ST_DEVSEL && scl_fall && cnt_q == sep_pkg::RX_BITS
        && sel_match && !start_ev && !stop_ev) |=> (state_q == sep_pkg::ST_DEV_ACK && sda_oe))
        else $error("matching select not acknowledged");
    a_busy_no_ack: assert property ((prog_busy && state_q != sep_pkg::ST_DEV_ACK)
        |=> state_q != sep_pkg::ST_DEV_ACK)
        else $error("acknowledge given while busy");
    a_addr_load: assert property ((state_q == sep_pkg::ST_ADDR && scl_fall && cnt_q == sep_pkg::RX_BITS
        && !start_ev && !stop_ev) |=> (addr_q[7:0] == $past(shift_q) && sda_oe))
        else $error("address byte not loaded");
    a_addr_step: assert property ((state_q == sep_pkg::ST_TX && scl_fall && cnt_q == sep_pkg::RX_BITS
        && !stop_ev && !start_ev) |=> addr_q == $past(addr_q) + 9'h001)
        else $error("counter did not advance");
    a_addr_wrap: assert property ((state_q == sep_pkg::ST_TX && scl_fall && cnt_q == sep_pkg::RX_BITS
        && addr_q == 9'h1FF && !stop_ev && !start_ev) |=> addr_q == 9'h000)
        else $error("counter did not wrap");
    a_nack_wait: assert property ((state_q == sep_pkg::ST_TX_ACK && scl_rise && sda_lvl
        && !start_ev && !stop_ev) |=> (state_q == sep_pkg::ST_WAIT && !sda_oe)[*2])
        else $error("nack did not end transfer");
    a_seq_next: assert property ((state_q == sep_pkg::ST_TX_ACK && scl_fall && acked_q
        && !start_ev && !stop_ev) |=> (state_q == sep_pkg::ST_TX && cnt_q == 4'h0))
        else $error("acked byte not followed");
    a_first_bit: assert property ((state_q == sep_pkg::ST_DEV_ACK && rw_q && scl_fall
        && !start_ev && !stop_ev) |=> sda_oe == ~$past(buf_out[sep_pkg::BIT_MSB]))
        else $error("first data bit wrong");
    a_stop_release: assert property (stop_ev |=> (!sda_oe && state_q == sep_pkg::ST_IDLE))
        else $error("line held after stop");
    a_buf_bound: assert property (buf_cnt_q <= sep_pkg::BUF_FULL)
        else $error("buffer overfilled");

    c_current_read: cover property (state_q == sep_pkg::ST_DEVSEL ##1 state_q == sep_pkg::ST_DEV_ACK && rw_q);
    c_random_read: cover property (state_q == sep_pkg::ST_ADDR_ACK ##[1:1000] state_q == sep_pkg::ST_TX);
    c_sequential: cover property (state_q == sep_pkg::ST_TX_ACK && acked_q && scl_fall);
    c_wrap: cover property (addr_q == 9'h1FF ##[1:1000] addr_q == 9'h000);
endmodule

// ---- sim/sep_i2c_master.sv ----
// Behavioural two-wire bus master facing the EEPROM read path.
// Assumes the testbench resolves the open-drain data wire with a pull-up.
module sep_i2c_master (
    input  wire logic core_clk,
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda_wire
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Low phase of 6 cycles: the target answers 5 edges after SCL falls,
    // so its bit settles before SCL rises
    task automatic bit_x(input logic b, output logic r);
        tick(2);
        sda_pull <= ~b;
        tick(4);
        scl <= 1'b1;
        tick(2);
        r = sda_wire;
        scl <= 1'b0;
    endtask

    // Waits for the target to release an ack before raising SCL
    task automatic start();
        tick(2);
        sda_pull <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(3);
        sda_pull <= 1'b1;
        tick(3);
        scl <= 1'b0;
    endtask

    task automatic stop();
        tick(1);
        sda_pull <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(3);
        sda_pull <= 1'b0;
        tick(3);
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask

    task automatic rbyte(input logic give_ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(~give_ack, r);
    endtask
endmodule

// ---- sim/serial_eeprom_read_path_tb_top.sv ----
// Self-checking bench for the EEPROM read path, driven through a bus master model.
// Assumes sep_pkg, sep_read_path and sep_i2c_master are compiled first.
module serial_eeprom_read_path_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] TYPE_CODE = 4'h5; // Arbitrary value
    localparam logic [1:0] CS        = 2'h2;
    logic       core_clk  = 1'b0;
    logic       rstn      = 1'b0;
    logic       scl;
    logic       m_pull;
    logic       sda_out;
    logic       sda_oe;
    logic [1:0] cs_pins   = CS;
    logic       wmode     = 1'b0;
    logic       busy      = 1'b0;
    logic       wr_en     = 1'b0;
    logic [8:0] wr_addr   = 9'h000;
    logic [7:0] wr_data   = 8'h00;
    wire        sda       = ~(m_pull | (sda_oe & ~sda_out));
    int         err_count = 0;
    int         n_tests   = 0;

    always #50 core_clk = ~core_clk;

    sep_read_path #(.DEV_TYPE_CODE(TYPE_CODE)) dut_u (
        .core_clk(core_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_low_bit(cs_pins[0]), .chip_select_high_bit(cs_pins[1]), .write_mode_sel(wmode),
        .prog_busy(busy),
        .mem_wr_en(wr_en), .mem_wr_addr(wr_addr), .mem_wr_data(wr_data));
    sep_i2c_master m_u (.core_clk(core_clk), .scl(scl), .sda_pull(m_pull), .sda_wire(sda));

    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] pat(input logic [8:0] a);
        return a[7:0] ^ (a[8] ? 8'hA5 : 8'h00);
    endfunction

    function automatic logic [7:0] sel(input logic [1:0] cs, input logic blk, input logic rd);
        return {TYPE_CODE, cs, blk, rd};
    endfunction

    task automatic select(input string what, input logic [7:0] b, input logic exp);
        logic ack;
        m_u.wbyte(b, ack);
        chk(what, {8'h00, ack}, {8'h00, exp});
    endtask

    // Acks every byte but the last one
    task automatic rd_seq(input string what, input logic [8:0] a0, input int n, input logic erased);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            m_u.rbyte(i < n - 1, d);
            chk(what, {1'b0, d}, {1'b0, erased ? 8'hFF : pat(9'(a0 + i))});
        end
    endtask

    task automatic t_erased();
        m_u.start();
        select("erased select", sel(CS, 1'b0, 1'b1), 1'b1);
        rd_seq("erased data", 9'h000, 2, 1'b1);
        m_u.stop();
    endtask

    task automatic preload();
        for (int a = 0; a < 512; a++) begin
            @(posedge core_clk);
            wr_en   <= 1'b1;
            wr_addr <= 9'(a);
            wr_data <= pat(9'(a));
        end
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    // Loads the top of block 1, then crosses the wrap point
    task automatic t_random();
        logic [7:0] d;
        m_u.start();
        select("dummy write select", sel(CS, 1'b1, 1'b0), 1'b1);
        select("address byte", 8'hFE, 1'b1);
        m_u.start();
        select("read select", sel(CS, 1'b1, 1'b1), 1'b1);
        rd_seq("wrap data", 9'h1FE, 4, 1'b0);
        m_u.rbyte(1'b0, d);
        chk("standby release", {1'b0, d}, 9'h0FF);
        m_u.stop();
    endtask

    task automatic t_current();
        wmode <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            m_u.start();
            select("current select", sel(CS, 1'b0, 1'b1), 1'b1);
            rd_seq("current data", 9'(2 + k), 1, 1'b0);
            m_u.stop();
        end
        wmode <= 1'b0;
    endtask

    task automatic t_refuse();
        logic [7:0] bad [3];
        bad = '{sel(2'h1, 1'b0, 1'b1), {~TYPE_CODE, CS, 2'h1}, sel(CS, 1'b0, 1'b1)};
        for (int k = 0; k < 3; k++) begin
            busy <= (k == 2);
            m_u.start();
            select("refused select", bad[k], 1'b0);
            m_u.stop();
        end
        // Pins move to the code refused above, so the match must follow the pins
        busy    <= 1'b0;
        cs_pins <= 2'h1;
        m_u.start();
        select("select after refusal", sel(2'h1, 1'b0, 1'b1), 1'b1);
        rd_seq("data after refusal", 9'h004, 1, 1'b0);
        m_u.stop();
    endtask

    // Tests need about 2200 cycles; the limit leaves a wide margin
    initial begin
        repeat (30000) @(posedge core_clk);
        err_count++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge core_clk);
        t_erased();
        preload();
        t_random();
        t_current();
        t_refuse();
        wrap_up();
    end
endmodule
